// >>> hw/plis_irq_top.sv
`timescale 1ns/1ns
`default_nettype none
module plis_irq_top (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // register port of the serial control interface
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rd_valid,
  // monitored conditions
  input  wire logic        conv_pll_lost_flag,
  input  wire logic        conv_pll_locked_flag,
  input  wire logic        link_pll_lost_flag,
  input  wire logic        link_pll_locked_flag,
  input  wire logic        align_rotate_event,
  input  wire logic        align_window_event,
  input  wire logic        align_trip_event,
  // interrupt request, active low
  output logic             irq_n
);

  localparam int unsigned NE = plis_pkg::NUM_EVT;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pll_en;
    logic [7:0] align_en;
    logic [7:0] rdata;
    logic       rvalid;
    logic       irq_n;
  } plis_top_st_t;

  plis_top_st_t st_r;
  plis_top_st_t st_nxt;

  logic [NE-1:0] evt_vec;
  logic [NE-1:0] en_vec;
  logic [NE-1:0] clr_vec;
  logic [NE-1:0] stat_vec;
  logic          any_pending;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // pll status byte from the event vector; reserved and foreign bits zero
  function automatic logic [7:0] pll_byte(input logic [NE-1:0] v);
    logic [7:0] b;
    b = plis_pkg::RST_STATUS;
    b[plis_pkg::BIT_CONV_PLL_LOST]   = v[plis_pkg::EVT_CONV_LOST];
    b[plis_pkg::BIT_CONV_PLL_LOCKED] = v[plis_pkg::EVT_CONV_LOCKED];
    b[plis_pkg::BIT_LINK_PLL_LOST]   = v[plis_pkg::EVT_LINK_LOST];
    b[plis_pkg::BIT_LINK_PLL_LOCKED] = v[plis_pkg::EVT_LINK_LOCKED];
    b[plis_pkg::BIT_STATUS_RSVD]     = 1'b0;
    pll_byte = b;
  endfunction

  function automatic logic [7:0] align_byte(input logic [NE-1:0] v);
    logic [7:0] b;
    b = plis_pkg::RST_STATUS;
    b[plis_pkg::BIT_ALIGN_ROTATE] = v[plis_pkg::EVT_ALIGN_ROTATE];
    b[plis_pkg::BIT_ALIGN_WINDOW] = v[plis_pkg::EVT_ALIGN_WINDOW];
    b[plis_pkg::BIT_ALIGN_TRIP]   = v[plis_pkg::EVT_ALIGN_TRIP];
    align_byte = b;
  endfunction

  // ----------------------------------------------------------------
  // event, enable and clear vectors
  // ----------------------------------------------------------------
  always_comb begin
    evt_vec = '0;
    evt_vec[plis_pkg::EVT_CONV_LOST]    = conv_pll_lost_flag;
    evt_vec[plis_pkg::EVT_CONV_LOCKED]  = conv_pll_locked_flag;
    evt_vec[plis_pkg::EVT_LINK_LOST]    = link_pll_lost_flag;
    evt_vec[plis_pkg::EVT_LINK_LOCKED]  = link_pll_locked_flag;
    evt_vec[plis_pkg::EVT_ALIGN_ROTATE] = align_rotate_event;
    evt_vec[plis_pkg::EVT_ALIGN_WINDOW] = align_window_event;
    evt_vec[plis_pkg::EVT_ALIGN_TRIP]   = align_trip_event;
  end

  always_comb begin
    en_vec = '0;
    en_vec[plis_pkg::EVT_CONV_LOST]    = st_r.pll_en[plis_pkg::BIT_CONV_PLL_LOST];
    en_vec[plis_pkg::EVT_CONV_LOCKED]  = st_r.pll_en[plis_pkg::BIT_CONV_PLL_LOCKED];
    en_vec[plis_pkg::EVT_LINK_LOST]    = st_r.pll_en[plis_pkg::BIT_LINK_PLL_LOST];
    en_vec[plis_pkg::EVT_LINK_LOCKED]  = st_r.pll_en[plis_pkg::BIT_LINK_PLL_LOCKED];
    en_vec[plis_pkg::EVT_ALIGN_ROTATE] = st_r.align_en[plis_pkg::BIT_ALIGN_ROTATE];
    en_vec[plis_pkg::EVT_ALIGN_WINDOW] = st_r.align_en[plis_pkg::BIT_ALIGN_WINDOW];
    en_vec[plis_pkg::EVT_ALIGN_TRIP]   = st_r.align_en[plis_pkg::BIT_ALIGN_TRIP];
  end

  // write-one-to-clear pulses; a zero bit leaves its latch alone
  always_comb begin
    clr_vec = '0;
    if (reg_wr_en && hit(reg_addr, plis_pkg::OFS_PLL_EVENT_STATUS)) begin
      clr_vec[plis_pkg::EVT_CONV_LOST]   = reg_wdata[plis_pkg::BIT_CONV_PLL_LOST];
      clr_vec[plis_pkg::EVT_CONV_LOCKED] = reg_wdata[plis_pkg::BIT_CONV_PLL_LOCKED];
      clr_vec[plis_pkg::EVT_LINK_LOST]   = reg_wdata[plis_pkg::BIT_LINK_PLL_LOST];
      clr_vec[plis_pkg::EVT_LINK_LOCKED] = reg_wdata[plis_pkg::BIT_LINK_PLL_LOCKED];
    end
    if (reg_wr_en && hit(reg_addr, plis_pkg::OFS_ALIGN_EVT_STATUS)) begin
      clr_vec[plis_pkg::EVT_ALIGN_ROTATE] = reg_wdata[plis_pkg::BIT_ALIGN_ROTATE];
      clr_vec[plis_pkg::EVT_ALIGN_WINDOW] = reg_wdata[plis_pkg::BIT_ALIGN_WINDOW];
      clr_vec[plis_pkg::EVT_ALIGN_TRIP]   = reg_wdata[plis_pkg::BIT_ALIGN_TRIP];
    end
  end

  // ----------------------------------------------------------------
  // event cells: sync, edge capture, live or latched view
  // ----------------------------------------------------------------
  plis_evt_cell #(
    .W (NE)
  ) u_cells (
    .clk_sys (clk_sys),
    .srst    (srst),
    .evt_in  (evt_vec),
    .irq_en  (en_vec),
    .clr_w1c (clr_vec),
    .status  (stat_vec),
    .pending (any_pending)
  );

  // ----------------------------------------------------------------
  // registers and read path
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    if (reg_wr_en && hit(reg_addr, plis_pkg::OFS_PLL_IRQ_ENABLE)) begin
      st_nxt.pll_en = reg_wdata;
    end
    if (reg_wr_en && hit(reg_addr, plis_pkg::OFS_LINK_ALIGN_IRQ_EN)) begin
      st_nxt.align_en = reg_wdata & plis_pkg::LINK_ALIGN_EN_MASK;
    end
    if (reg_rd_en) begin
      st_nxt.rvalid = 1'b1;
      // unmapped addresses answer zero so software sees a defined value
      unique case (1'b1)
        hit(reg_addr, plis_pkg::OFS_PLL_IRQ_ENABLE): begin
          st_nxt.rdata = st_r.pll_en;
        end
        hit(reg_addr, plis_pkg::OFS_LINK_ALIGN_IRQ_EN): begin
          st_nxt.rdata = st_r.align_en;
        end
        hit(reg_addr, plis_pkg::OFS_PLL_EVENT_STATUS): begin
          st_nxt.rdata = pll_byte(stat_vec);
        end
        hit(reg_addr, plis_pkg::OFS_ALIGN_EVT_STATUS): begin
          st_nxt.rdata = align_byte(stat_vec);
        end
        default: begin
          st_nxt.rdata = plis_pkg::RST_STATUS;
        end
      endcase
    end
    // low while any enabled bit holds its latch, high otherwise
    st_nxt.irq_n = ~any_pending;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r.pll_en   <= plis_pkg::RST_ENABLE;
      st_r.align_en <= plis_pkg::RST_ENABLE;
      st_r.rdata    <= plis_pkg::RST_STATUS;
      st_r.rvalid   <= 1'b0;
      st_r.irq_n    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata    = st_r.rdata;
  assign reg_rd_valid = st_r.rvalid;
  assign irq_n        = st_r.irq_n;

endmodule // plis_irq_top
`default_nettype wire

// >>> shared/plis_pkg.sv
`default_nettype none
package plis_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses of the control port)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_PLL_IRQ_ENABLE   = 12'h001F;
  localparam logic [11:0] OFS_LINK_ALIGN_IRQ_EN = 12'h0021;
  localparam logic [11:0] OFS_PLL_EVENT_STATUS = 12'h0023;
  localparam logic [11:0] OFS_ALIGN_EVT_STATUS = 12'h00FE;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // pll_event_status and pll enable register share bit positions
  localparam int unsigned BIT_CONV_PLL_LOST   = 7;
  localparam int unsigned BIT_CONV_PLL_LOCKED = 6;
  localparam int unsigned BIT_STATUS_RSVD     = 5;
  localparam int unsigned BIT_LINK_PLL_LOST   = 4;
  localparam int unsigned BIT_LINK_PLL_LOCKED = 3;
  // link_align_irq_enable and align event status
  localparam int unsigned BIT_ALIGN_ROTATE = 2;
  localparam int unsigned BIT_ALIGN_WINDOW = 1;
  localparam int unsigned BIT_ALIGN_TRIP   = 0;
  // bits of link_align_irq_enable that read back (6:5 read zero)
  localparam logic [7:0] LINK_ALIGN_EN_MASK = 8'h9F;

  // ----------------------------------------------------------------
  // event vector order inside the block
  // ----------------------------------------------------------------
  localparam int unsigned NUM_EVT          = 7;
  localparam int unsigned EVT_ALIGN_TRIP   = 0;
  localparam int unsigned EVT_ALIGN_WINDOW = 1;
  localparam int unsigned EVT_ALIGN_ROTATE = 2;
  localparam int unsigned EVT_LINK_LOCKED  = 3;
  localparam int unsigned EVT_LINK_LOST    = 4;
  localparam int unsigned EVT_CONV_LOCKED  = 5;
  localparam int unsigned EVT_CONV_LOST    = 6;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam int unsigned READ_LATENCY = 1;

endpackage : plis_pkg
`default_nettype wire

// >>> hw/plis_evt_cell.sv
`timescale 1ns/1ns
`default_nettype none
module plis_evt_cell #(
  parameter int unsigned W = 7
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] evt_in,
  input  wire logic [W-1:0] irq_en,
  input  wire logic [W-1:0] clr_w1c,
  output logic      [W-1:0] status,
  output logic              pending
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (W < 1 || W > 32) begin : g_bad_w
    $error("plis_evt_cell: W must be 1 to 32");
  end

  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] prev;
    logic [W-1:0] latch;
    logic [W-1:0] stat;
    logic         pend;
  } plis_cell_st_t;

  plis_cell_st_t st_r;
  plis_cell_st_t st_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [W-1:0] rise;
    logic [W-1:0] lat;
    rise   = '0;
    lat    = '0;
    st_nxt = st_r;
    // conditions come from analog or other logic: two flops first
    st_nxt.sync1 = evt_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    rise         = st_r.sync2 & ~st_r.prev;
    // a rise in the clearing cycle survives: set wins over clear
    lat          = irq_en & ((st_r.latch & ~clr_w1c) | rise);
    st_nxt.latch = lat;
    // disabled bits show the live synchronised condition
    st_nxt.stat  = (irq_en & lat) | (~irq_en & st_r.sync2);
    st_nxt.pend  = |lat;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status  = st_r.stat;
  assign pending = st_r.pend;

endmodule // plis_evt_cell
`default_nettype wire

// >>> verif/plis_irq_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module plis_irq_asserts (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rd_valid,
  input wire logic        conv_pll_lost_flag,
  input wire logic        conv_pll_locked_flag,
  input wire logic        link_pll_lost_flag,
  input wire logic        link_pll_locked_flag,
  input wire logic        align_rotate_event,
  input wire logic        align_window_event,
  input wire logic        align_trip_event,
  input wire logic        irq_n
);
  // enables rebuilt from port writes, since the real ones are not visible here
  logic [7:0] en_p_r;
  logic [7:0] en_a_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_p_r <= 8'h00;
      en_a_r <= 8'h00;
    end else if (reg_wr_en && reg_addr == plis_pkg::OFS_PLL_IRQ_ENABLE) begin
      en_p_r <= reg_wdata;
    end else if (reg_wr_en && reg_addr == plis_pkg::OFS_LINK_ALIGN_IRQ_EN) begin
      en_a_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // no write allowed in the window, as a write could legally clear the latch
  sequence s_rise(f, en);
    $rose(f) && en && !reg_wr_en ##1 (!reg_wr_en) [*3];
  endsequence
  property p_latch(f, en);
    s_rise(f, en) |=> !irq_n;
  endproperty
  a_conv_lost_irq: assert property (p_latch(conv_pll_lost_flag, en_p_r[7]))
    else $error("conv lost");
  a_conv_lock_irq: assert property (p_latch(conv_pll_locked_flag, en_p_r[6]))
    else $error("conv locked");
  a_link_lost_irq: assert property (p_latch(link_pll_lost_flag, en_p_r[4]))
    else $error("link lost");
  a_link_lock_irq: assert property (p_latch(link_pll_locked_flag, en_p_r[3]))
    else $error("link locked");
  a_rotate_irq: assert property (p_latch(align_rotate_event, en_a_r[2]))
    else $error("rotate");
  a_window_irq: assert property (p_latch(align_window_event, en_a_r[1]))
    else $error("window");
  a_trip_irq: assert property (p_latch(align_trip_event, en_a_r[0]))
    else $error("trip");
  a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("no read answer");
  a_rd_quiet: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("stray read answer");
  a_rsvd_zero: assert property (reg_rd_en && reg_addr == plis_pkg::OFS_PLL_EVENT_STATUS
    |=> reg_rdata[5] == 1'b0 && reg_rdata[2:0] == 3'b000) else $error("reserved bits set");
  a_irq_release: assert property (((en_p_r & 8'hd8) == 8'h00 && en_a_r[2:0] == 3'b000) [*4]
    |-> irq_n) else $error("irq held");
endmodule // plis_irq_asserts
`default_nettype wire

// >>> verif/plis_irq_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module plis_irq_top_tb;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] reg_addr = 12'h0000;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rd_valid;
  logic        irq_n;
  logic [6:0]  ev = 7'h00;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          en_p = 0;
  int          en_a = 0;
  int          lat = 0;
  int          prv = 0;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end

  plis_irq_top plis_irq_top_inst (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .conv_pll_lost_flag(ev[6]), .conv_pll_locked_flag(ev[5]),
    .link_pll_lost_flag(ev[4]), .link_pll_locked_flag(ev[3]), .align_rotate_event(ev[2]),
    .align_window_event(ev[1]), .align_trip_event(ev[0]), .irq_n(irq_n));

  // enables in event order: conv lost, conv locked, link lost, link locked, rotate, window, trip
  function automatic int en7();
    return {en_p[7], en_p[6], en_p[4], en_p[3], en_a[2:0]};
  endfunction

  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    case (a)
      plis_pkg::OFS_PLL_IRQ_ENABLE: en_p = d;
      plis_pkg::OFS_LINK_ALIGN_IRQ_EN: en_a = d;
      plis_pkg::OFS_PLL_EVENT_STATUS: lat &= ~{d[7], d[6], d[4], d[3], 3'b000};
      plis_pkg::OFS_ALIGN_EVT_STATUS: lat &= ~{4'h0, d[2:0]};
      default: ;
    endcase
    lat &= en7();
  endtask

  task automatic rd(input logic [11:0] a, input int e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    `CHK("rd_valid", 1'b1, reg_rd_valid)
    `CHK("rdata", e, reg_rdata)
  endtask

  // only a rise while enabled latches; a level already high when enabled does not
  task automatic evset(input logic [6:0] v);
    @(negedge clk_sys);
    ev = v;
    lat |= v & ~prv & en7();
    prv = v;
    repeat (5) @(negedge clk_sys);
  endtask

  task automatic chk_all();
    int s;
    s = lat | (ev & ~en7());
    rd(plis_pkg::OFS_PLL_EVENT_STATUS, {s[6], s[5], 1'b0, s[4], s[3], 3'b000});
    rd(plis_pkg::OFS_ALIGN_EVT_STATUS, s[2:0]);
    rd(plis_pkg::OFS_PLL_IRQ_ENABLE, en_p);
    rd(plis_pkg::OFS_LINK_ALIGN_IRQ_EN, en_a & 8'h9f);
    `CHK("irq_n", lat == 0, irq_n)
  endtask

  initial begin
    void'($urandom(32'hc658_8ebb));
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    chk_all();
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wr(plis_pkg::OFS_PLL_IRQ_ENABLE, 8'hff);
      wr(plis_pkg::OFS_LINK_ALIGN_IRQ_EN, 8'hff);
      evset(7'(1 << i));
      evset(7'h00);
      chk_all();
      wr(plis_pkg::OFS_PLL_EVENT_STATUS, 8'h00);
      wr(plis_pkg::OFS_ALIGN_EVT_STATUS, 8'h00);
      wr(12'h0022, 8'hff);
      chk_all();
      wr(plis_pkg::OFS_PLL_EVENT_STATUS, 8'hff);
      wr(plis_pkg::OFS_ALIGN_EVT_STATUS, 8'hff);
      chk_all();
      rd(12'h0022, 0);
    end
    $display("test directed done");
    for (int i = 0; i < 60; i++) begin
      case ($urandom_range(3))
        0: evset(7'($urandom));
        1: wr(plis_pkg::OFS_PLL_IRQ_ENABLE, 8'($urandom));
        2: wr(plis_pkg::OFS_LINK_ALIGN_IRQ_EN, 8'($urandom));
        default: wr($urandom_range(1) ? plis_pkg::OFS_PLL_EVENT_STATUS
                                      : plis_pkg::OFS_ALIGN_EVT_STATUS, 8'($urandom));
      endcase
      chk_all();
    end
    $display("test random done");
    finish_test();
  end
endmodule // plis_irq_top_tb

bind plis_irq_top plis_irq_asserts plis_irq_asserts_inst (
  .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .conv_pll_lost_flag(conv_pll_lost_flag),
  .conv_pll_locked_flag(conv_pll_locked_flag), .link_pll_lost_flag(link_pll_lost_flag),
  .link_pll_locked_flag(link_pll_locked_flag), .align_rotate_event(align_rotate_event),
  .align_window_event(align_window_event), .align_trip_event(align_trip_event),
  .irq_n(irq_n));
`default_nettype wire
